// >>> rtl/pas_pkg.sv
// pas_pkg: offsets, field positions, reset values and counts
// assumes: shared by the management engine and the register bank
package pas_pkg;
	// ****************************************
	// register offsets on the management bus
	// ****************************************
	localparam logic [4:0] REG_ERR_STAT = 5'h1c;
	localparam logic [4:0] REG_MODE = 5'h1d;
	localparam logic [4:0] REG_MPORT = 5'h1e;
	// ****************************************
	// error and general status fields
	// ****************************************
	localparam int ST_SWAP = 13;
	localparam int CT_FORCE_SWAP = 12;
	localparam int CT_AUTOX_DIS = 11;
	localparam int ST_MANCH = 10;
	localparam int ST_EOF = 9;
	localparam int ST_NEG_ON = 3;
	localparam int ST_FORCE = 2;
	localparam int ST_SPEED = 1;
	localparam int ST_FDX = 0;
	// ****************************************
	// mode and multi-port fields
	// ****************************************
	localparam int MD_LINK_DIS = 3;
	localparam int MD_IPG = 1;
	localparam int MP_HCD_HI = 15;
	localparam int MP_HCD_LO = 11;
	localparam int MP_RESTART = 8;
	localparam int MP_DONE = 7;
	localparam int MP_ACKC = 6;
	localparam int MP_ACKD = 5;
	localparam int MP_ABIL = 4;
	localparam int MP_ISO = 3;
	localparam int MP_SERIAL = 1;
	// ****************************************
	// reset values and frame counts
	// ****************************************
	localparam logic CTL_RST = 1'b0;
	localparam logic [4:0] HCD_RST = 5'h00;
	localparam logic [5:0] PRE_LEN = 6'h20;
	localparam logic [5:0] HDR_BITS = 6'h0d;
	localparam logic [5:0] DATA_BITS = 6'h10;
	localparam logic [1:0] OP_RD = 2'h2;
	localparam logic [1:0] OP_WR = 2'h1;
	localparam logic [2:0] IPG_MIN = 3'h1;
	localparam logic [2:0] IPG_MAX = 3'h4;
endpackage

// >>> rtl/pas_mgmt_if.sv
// pas_mgmt_if: register requests from the serial engine to the bank
// assumes: one mclk domain, strobes are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface pas_mgmt_if;
	logic rd_stb;
	logic wr_stb;
	logic [4:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport link(output rd_stb, output wr_stb, output addr, output wdata, input rdata);
	modport regs(input rd_stb, input wr_stb, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// >>> rtl/pas_err_latch.sv
// pas_err_latch: latched-high error flags and the receive error strobe
// assumes: events are one-cycle pulses on mclk, already speed-qualified
`timescale 1ns/1ps
`default_nettype none
module pas_err_latch (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [1:0] evt,
	input wire logic clr,
	output logic [1:0] flags,
	output logic rxer
);
	// ****************************************
	// flags
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_flag
			// set beats the read clear so no error slips by
			always_ff @(posedge mclk) begin
				if (reset)
					flags[i] <= 1'b0;
				else if (evt[i])
					flags[i] <= 1'b1;
				else if (clr)
					flags[i] <= 1'b0;
			end
			flag_hold_a: assert property (@(posedge mclk) disable iff (reset)
				flags[i] && !clr |=> flags[i]) else $error("error flag dropped");
			flag_set_a: assert property (@(posedge mclk) disable iff (reset)
				evt[i] |=> flags[i]) else $error("error flag missed");
		end
	endgenerate
	always_ff @(posedge mclk) begin
		if (reset)
			rxer <= 1'b0;
		else
			rxer <= |evt;
	end
	rxer_evt_a: assert property (@(posedge mclk) disable iff (reset)
		$rose(flags[0]) || $rose(flags[1]) |-> rxer) else $error("no rxer on error");
endmodule
`default_nettype wire

// >>> rtl/pas_mdio_slave.sv
// pas_mdio_slave: serial management frame engine
// assumes: mdc and mdio already pass two flip-flops; mdc far slower than mclk
`timescale 1ns/1ps
`default_nettype none
module pas_mdio_slave (
	input wire logic mclk,
	input wire logic reset,
	input wire logic mdc_s,
	input wire logic mdio_s,
	input wire logic [4:0] port_addr,
	output logic mdio_out,
	output logic mdio_oe,
	pas_mgmt_if.link m
);
	typedef enum logic [1:0] {
		S_PRE = 2'b00,
		S_HDR = 2'b01,
		S_TA = 2'b11,
		S_DATA = 2'b10
	} pas_mdio_e;
	pas_mdio_e st;
	logic mdc_d;
	logic mdc_rise;
	logic [5:0] cnt;
	logic [11:0] hdr;
	logic [12:0] next_hdr;
	logic [15:0] shreg;
	logic is_rd;
	logic hit;
	assign mdc_rise = mdc_s & ~mdc_d;
	assign next_hdr = {hdr, mdio_s};
	assign hit = next_hdr[12] && next_hdr[9:5] == port_addr
		&& (next_hdr[11:10] == pas_pkg::OP_RD || next_hdr[11:10] == pas_pkg::OP_WR);
	// ****************************************
	// frame walk
	// ****************************************
	always_ff @(posedge mclk) begin
		if (reset) begin
			st <= S_PRE;
			mdc_d <= 1'b0;
			cnt <= 6'h00;
			hdr <= 12'h000;
			shreg <= 16'h0000;
			is_rd <= 1'b0;
			mdio_out <= 1'b0;
			mdio_oe <= 1'b0;
			m.rd_stb <= 1'b0;
			m.wr_stb <= 1'b0;
			m.addr <= 5'h00;
			m.wdata <= 16'h0000;
		end else begin
			mdc_d <= mdc_s;
			m.rd_stb <= 1'b0;
			m.wr_stb <= 1'b0;
			if (m.rd_stb)
				shreg <= m.rdata;
			if (mdc_rise) begin
				unique case (st)
					S_PRE: begin
						if (mdio_s)
							cnt <= (cnt == pas_pkg::PRE_LEN) ? cnt : cnt + 6'h01;
						else if (cnt == pas_pkg::PRE_LEN) begin
							st <= S_HDR;
							cnt <= 6'h00;
						end else
							cnt <= 6'h00;
					end
					S_HDR: begin
						hdr <= next_hdr[11:0];
						cnt <= cnt + 6'h01;
						if (cnt == pas_pkg::HDR_BITS - 6'h01) begin
							// frames for another port are let pass silently
							st <= hit ? S_TA : S_PRE;
							cnt <= 6'h00;
							is_rd <= next_hdr[11:10] == pas_pkg::OP_RD;
							m.addr <= next_hdr[4:0];
							m.rd_stb <= hit && next_hdr[11:10] == pas_pkg::OP_RD;
						end
					end
					S_TA: begin
						cnt <= cnt + 6'h01;
						if (cnt == 6'h00) begin
							mdio_oe <= is_rd;
							mdio_out <= 1'b0;
						end else begin
							st <= S_DATA;
							cnt <= 6'h00;
							mdio_out <= is_rd & shreg[15];
							if (is_rd)
								shreg <= {shreg[14:0], 1'b0};
						end
					end
					S_DATA: begin
						cnt <= cnt + 6'h01;
						if (is_rd) begin
							mdio_out <= shreg[15];
							shreg <= {shreg[14:0], 1'b0};
						end else
							shreg <= {shreg[14:0], mdio_s};
						if (cnt == pas_pkg::DATA_BITS - 6'h01) begin
							st <= S_PRE;
							cnt <= 6'h00;
							mdio_oe <= 1'b0;
							mdio_out <= 1'b0;
							m.wr_stb <= ~is_rd;
							m.wdata <= {shreg[14:0], mdio_s};
						end
					end
				endcase
			end
		end
	end
	drive_read_a: assert property (@(posedge mclk) disable iff (reset)
		mdio_oe |-> is_rd && st != S_PRE && st != S_HDR) else $error("drive outside read");
endmodule
`default_nettype wire

// >>> rtl/pas_aux_regs.sv
// pas_aux_regs: auxiliary status and control bank of one transceiver port
// assumes: status inputs come from mclk logic; pins and mdc arrive unsynchronised
`timescale 1ns/1ps
`default_nettype none
// Contract
// - swap status reads actual pair swap
// - force swap bit, else auto crossover
// - disable bit turns off auto crossover
// - manchester violation sets flag at 10M
// - bad or missing end-of-frame sets flag at 10M
// - flags hold until read or reset
// - each flagged error pulses rxer
// - negotiation indication is control and pin
// - forced indication zero in two cases
// - speed bit shows real speed
// - duplex bit shows full duplex
// - mode bit disables link indicator
// - short gap inserts two idles
// - result bits report negotiated mode
// - restart bit self clears, zero ignored
// - done bit shows negotiation complete
// - ack complete and ack detected bits
// - ability bit shows waiting for partner
// - isolate bit enters super isolate
// - serial bit enables serial mode
// - super isolate quiets mii and pulses
// - serial mode only at 10M
// - result bits clear on restart
// - restart needs negotiation, reads zero
module pas_aux_regs (
	input wire logic mclk,
	input wire logic reset,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	input wire logic [4:0] port_addr,
	input wire logic negotiation_enable_pin,
	input wire logic force_fast_speed_pin,
	input wire logic tx_clk,
	input wire logic tx_en,
	input wire logic ctl_neg_enable,
	input wire logic ctl_speed_select,
	input wire logic cross_detected,
	input wire logic speed_fast,
	input wire logic full_duplex,
	input wire logic manch_err_evt,
	input wire logic eof_err_evt,
	input wire logic link_up,
	input wire logic neg_done,
	input wire logic ack_done,
	input wire logic ack_seen,
	input wire logic ability_wait,
	input wire logic result_load,
	input wire logic [4:0] result_in,
	output logic pair_swap,
	output logic auto_cross_en,
	output logic rxer,
	output logic link_led,
	output logic insert_idles,
	output logic neg_restart,
	output logic super_isolate,
	output logic link_pulse_en,
	output logic serial_mode
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	localparam int NPIN = 11;
	logic [NPIN-1:0] pin_s1;
	logic [NPIN-1:0] pin_s2;
	logic mdc_s;
	logic mdio_s;
	logic negotiation_enable_pin_s;
	logic force_fast_speed_pin_s;
	logic txc_s;
	logic txen_s;
	logic [4:0] addr_s;
	// only the second stage is read anywhere
	always_ff @(posedge mclk) begin
		if (reset) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
		end else begin
			pin_s1 <= {port_addr, tx_en, tx_clk, force_fast_speed_pin,
				negotiation_enable_pin, mdio_in, mdc};
			pin_s2 <= pin_s1;
		end
	end
	assign mdc_s = pin_s2[0];
	assign mdio_s = pin_s2[1];
	assign negotiation_enable_pin_s = pin_s2[2];
	assign force_fast_speed_pin_s = pin_s2[3];
	assign txc_s = pin_s2[4];
	assign txen_s = pin_s2[5];
	assign addr_s = pin_s2[10:6];
	// ****************************************
	// management engine
	// ****************************************
	pas_mgmt_if mg ();
	pas_mdio_slave u_mdio (
		.mclk(mclk),
		.reset(reset),
		.mdc_s(mdc_s),
		.mdio_s(mdio_s),
		.port_addr(addr_s),
		.mdio_out(mdio_out),
		.mdio_oe(mdio_oe),
		.m(mg.link)
	);
	logic wr_err;
	logic wr_mode;
	logic wr_mport;
	logic rd_err;
	assign wr_err = mg.wr_stb && mg.addr == pas_pkg::REG_ERR_STAT;
	assign wr_mode = mg.wr_stb && mg.addr == pas_pkg::REG_MODE;
	assign wr_mport = mg.wr_stb && mg.addr == pas_pkg::REG_MPORT;
	assign rd_err = mg.rd_stb && mg.addr == pas_pkg::REG_ERR_STAT;
	// ****************************************
	// control bits
	// ****************************************
	logic ctl_swap;
	logic ctl_autox_dis;
	logic mode_link_dis;
	logic mode_ipg;
	logic mp_iso;
	logic mp_serial;
	always_ff @(posedge mclk) begin
		if (reset) begin
			ctl_swap <= pas_pkg::CTL_RST;
			ctl_autox_dis <= pas_pkg::CTL_RST;
		end else if (wr_err) begin
			ctl_swap <= mg.wdata[pas_pkg::CT_FORCE_SWAP];
			ctl_autox_dis <= mg.wdata[pas_pkg::CT_AUTOX_DIS];
		end
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			mode_link_dis <= pas_pkg::CTL_RST;
			mode_ipg <= pas_pkg::CTL_RST;
		end else if (wr_mode) begin
			mode_link_dis <= mg.wdata[pas_pkg::MD_LINK_DIS];
			mode_ipg <= mg.wdata[pas_pkg::MD_IPG];
		end
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			mp_iso <= pas_pkg::CTL_RST;
			mp_serial <= pas_pkg::CTL_RST;
		end else if (wr_mport) begin
			mp_iso <= mg.wdata[pas_pkg::MP_ISO];
			mp_serial <= mg.wdata[pas_pkg::MP_SERIAL];
		end
	end
	// ****************************************
	// negotiation indications and restart
	// ****************************************
	logic neg_on;
	logic force_ind;
	logic [4:0] hcd;
	assign neg_on = ctl_neg_enable & negotiation_enable_pin_s;
	// zero when both pins low or both control bits written low
	assign force_ind = ~((~negotiation_enable_pin_s & ~force_fast_speed_pin_s) | (~ctl_neg_enable & ~ctl_speed_select));
	// restart is a pulse, never stored, so it reads back zero
	always_ff @(posedge mclk) begin
		if (reset)
			neg_restart <= 1'b0;
		else
			neg_restart <= wr_mport & mg.wdata[pas_pkg::MP_RESTART] & neg_on;
	end
	always_ff @(posedge mclk) begin
		if (reset)
			hcd <= pas_pkg::HCD_RST;
		else if (neg_restart)
			hcd <= pas_pkg::HCD_RST;
		else if (result_load)
			hcd <= result_in;
	end
	// ****************************************
	// error flags
	// ****************************************
	logic [1:0] err_flags;
	logic [1:0] err_evt;
	// errors only mean anything at 10 Mb/s
	assign err_evt = {manch_err_evt, eof_err_evt} & {2{~speed_fast}};
	pas_err_latch u_err (
		.mclk(mclk),
		.reset(reset),
		.evt(err_evt),
		.clr(rd_err),
		.flags(err_flags),
		.rxer(rxer)
	);
	// ****************************************
	// port controls
	// ****************************************
	always_ff @(posedge mclk) begin
		if (reset) begin
			pair_swap <= 1'b0;
			auto_cross_en <= 1'b1;
			link_led <= 1'b0;
			super_isolate <= 1'b0;
			link_pulse_en <= 1'b1;
			serial_mode <= 1'b0;
		end else begin
			pair_swap <= ctl_swap | (~ctl_autox_dis & cross_detected);
			auto_cross_en <= ~ctl_autox_dis;
			link_led <= link_up & ~mode_link_dis;
			super_isolate <= mp_iso;
			link_pulse_en <= ~mp_iso;
			serial_mode <= mp_serial & ~speed_fast;
		end
	end
	// ****************************************
	// gap guard
	// ****************************************
	// sampled transmit clock: fine for 25 MHz, no use above mclk/4
	logic txc_d;
	logic txen_d;
	logic [2:0] gap;
	always_ff @(posedge mclk) begin
		if (reset) begin
			txc_d <= 1'b0;
			txen_d <= 1'b0;
			gap <= 3'h0;
			insert_idles <= 1'b0;
		end else begin
			txc_d <= txc_s;
			insert_idles <= 1'b0;
			if (txc_s & ~txc_d) begin
				txen_d <= txen_s;
				if (txen_s) begin
					insert_idles <= mode_ipg & ~txen_d
						& gap >= pas_pkg::IPG_MIN & gap <= pas_pkg::IPG_MAX;
					gap <= 3'h0;
				end else if (gap != 3'h7)
					gap <= gap + 3'h1;
			end
		end
	end
	// ****************************************
	// read data
	// ****************************************
	always_comb begin
		mg.rdata = 16'h0000;
		unique case (mg.addr)
			pas_pkg::REG_ERR_STAT: begin
				mg.rdata[pas_pkg::ST_SWAP] = pair_swap;
				mg.rdata[pas_pkg::CT_FORCE_SWAP] = ctl_swap;
				mg.rdata[pas_pkg::CT_AUTOX_DIS] = ctl_autox_dis;
				mg.rdata[pas_pkg::ST_MANCH] = err_flags[1];
				mg.rdata[pas_pkg::ST_EOF] = err_flags[0];
				mg.rdata[pas_pkg::ST_NEG_ON] = neg_on;
				mg.rdata[pas_pkg::ST_FORCE] = force_ind;
				mg.rdata[pas_pkg::ST_SPEED] = speed_fast;
				mg.rdata[pas_pkg::ST_FDX] = full_duplex;
			end
			pas_pkg::REG_MODE: begin
				mg.rdata[pas_pkg::MD_LINK_DIS] = mode_link_dis;
				mg.rdata[pas_pkg::MD_IPG] = mode_ipg;
			end
			pas_pkg::REG_MPORT: begin
				mg.rdata[pas_pkg::MP_HCD_HI:pas_pkg::MP_HCD_LO] = hcd;
				mg.rdata[pas_pkg::MP_DONE] = neg_done;
				mg.rdata[pas_pkg::MP_ACKC] = ack_done;
				mg.rdata[pas_pkg::MP_ACKD] = ack_seen;
				mg.rdata[pas_pkg::MP_ABIL] = ability_wait;
				mg.rdata[pas_pkg::MP_ISO] = mp_iso;
				mg.rdata[pas_pkg::MP_SERIAL] = mp_serial;
			end
			default: mg.rdata = 16'h0000;
		endcase
	end
	// ****************************************
	// checks
	// ****************************************
	swap_status_a: assert property (@(posedge mclk) disable iff (reset)
		##1 pair_swap == $past(ctl_swap | (~ctl_autox_dis & cross_detected)))
		else $error("swap status wrong");
	force_swap_a: assert property (@(posedge mclk) disable iff (reset)
		ctl_swap |=> pair_swap) else $error("forced swap not applied");
	autox_off_a: assert property (@(posedge mclk) disable iff (reset)
		!ctl_swap && ctl_autox_dis |=> !pair_swap && !auto_cross_en)
		else $error("auto crossover not disabled");
	fast_no_err_a: assert property (@(posedge mclk) disable iff (reset)
		speed_fast && !rd_err && err_flags == 2'b00 |=> err_flags == 2'b00)
		else $error("error flag set at 100M");
	neg_ind_a: assert property (@(posedge mclk) disable iff (reset)
		mg.addr == pas_pkg::REG_ERR_STAT |->
		mg.rdata[pas_pkg::ST_NEG_ON] == (ctl_neg_enable && negotiation_enable_pin_s))
		else $error("negotiation indication wrong");
	force_ind_a: assert property (@(posedge mclk) disable iff (reset)
		!ctl_neg_enable && !ctl_speed_select |-> !force_ind)
		else $error("forced indication not zero");
	led_off_a: assert property (@(posedge mclk) disable iff (reset)
		mode_link_dis |=> !link_led) else $error("link indicator not disabled");
	idle_ins_a: assert property (@(posedge mclk) disable iff (reset)
		insert_idles |-> mode_ipg && gap == 3'h0 && txen_d)
		else $error("idle insert without short gap");
	restart_pulse_a: assert property (@(posedge mclk) disable iff (reset)
		neg_restart |=> !neg_restart) else $error("restart not self clearing");
	restart_gate_a: assert property (@(posedge mclk) disable iff (reset)
		neg_restart |-> $past(neg_on) && mg.rdata[pas_pkg::MP_RESTART] == 1'b0)
		else $error("restart while negotiation off");
	hcd_clear_a: assert property (@(posedge mclk) disable iff (reset)
		neg_restart |=> hcd == pas_pkg::HCD_RST) else $error("result bits not cleared");
	iso_quiet_a: assert property (@(posedge mclk) disable iff (reset)
		mp_iso |=> super_isolate && !link_pulse_en) else $error("isolate not applied");
	serial_slow_a: assert property (@(posedge mclk) disable iff (reset)
		speed_fast |=> !serial_mode) else $error("serial mode at 100M");
	serial_on_a: assert property (@(posedge mclk) disable iff (reset)
		mp_serial && !speed_fast |=> serial_mode) else $error("serial mode not enabled");
	speed_ind_a: assert property (@(posedge mclk) disable iff (reset)
		mg.addr == pas_pkg::REG_ERR_STAT |-> mg.rdata[pas_pkg::ST_SPEED] == speed_fast)
		else $error("speed indication wrong");
	duplex_ind_a: assert property (@(posedge mclk) disable iff (reset)
		mg.addr == pas_pkg::REG_ERR_STAT |-> mg.rdata[pas_pkg::ST_FDX] == full_duplex)
		else $error("duplex indication wrong");
	result_load_a: assert property (@(posedge mclk) disable iff (reset)
		result_load && !neg_restart |=> hcd == $past(result_in))
		else $error("result bits not loaded");
	progress_bits_a: assert property (@(posedge mclk) disable iff (reset)
		mg.addr == pas_pkg::REG_MPORT |-> mg.rdata[pas_pkg::MP_DONE] == neg_done
		&& mg.rdata[pas_pkg::MP_ABIL] == ability_wait)
		else $error("progress bits wrong");
endmodule
`default_nettype wire

// >>> verification/pas_station_model.sv
// pas_station_model: management station framing reads and writes on mdc/mdio
// assumes: the bench resolves the wire with a pull-up; mdc is still between frames
`timescale 1ns/1ps
`default_nettype none
module pas_station_model (
	output logic mdc,
	output logic mdio_drv,
	output logic mdio_en,
	input wire logic mdio_w
);
	// ****************************************
	// bit clocking, 48 ns per mdc period
	// ****************************************
	localparam time HALF = 24;
	initial begin
		mdc = 1'b0;
		mdio_drv = 1'b0;
		mdio_en = 1'b0;
	end
	// data changes while mdc is low, the port samples at the rise
	task automatic clk_bit(input logic b);
		mdio_drv = b;
		#HALF mdc = 1'b1;
		#HALF mdc = 1'b0;
	endtask
	// ****************************************
	// one whole frame, own preamble every time
	// ****************************************
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [45:0] hdr;
		rd = 16'h0000;
		hdr = {32'hffffffff, 2'b01, op, phy, rg};
		mdio_en = 1'b1;
		for (int i = 45; i >= 0; i--) begin
			clk_bit(hdr[i]);
		end
		if (op == pas_pkg::OP_WR) begin
			clk_bit(1'b1);
			clk_bit(1'b0);
			// all 16 bits, msb first
			for (int i = 15; i >= 0; i--) begin
				clk_bit(wd[i]);
			end
		end else begin
			// released for turnaround; the port answers from here
			mdio_en = 1'b0;
			clk_bit(1'b1);
			clk_bit(1'b1);
			for (int i = 0; i < 16; i++) begin
				#HALF mdc = 1'b1;
				rd = {rd[14:0], mdio_w};
				#HALF mdc = 1'b0;
			end
		end
		mdio_en = 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> verification/pas_aux_regs_tb.sv
// pas_aux_regs_tb: register bank checked through management frames
// assumes: station model on mdc/mdio, status inputs driven directly by the bench
`timescale 1ns/1ps
`default_nettype none
module pas_aux_regs_tb;
	// ****************************************
	// clocks, pins and counters
	// ****************************************
	logic mclk = 1'b0, reset = 1'b1, tx_clk = 1'b0, tx_en = 1'b0;
	logic negotiation_enable_pin = 1'b1, force_fast_speed_pin = 1'b0;
	logic ctl_neg_enable = 1'b1, ctl_speed_select = 1'b0, cross_detected = 1'b0;
	logic speed_fast = 1'b0, full_duplex = 1'b0, manch_err_evt = 1'b0, eof_err_evt = 1'b0;
	logic link_up = 1'b0, neg_done = 1'b0, ack_done = 1'b0, ack_seen = 1'b0;
	logic ability_wait = 1'b0, result_load = 1'b0;
	logic [4:0] result_in = 5'h00, tgt = 5'h05;
	logic [4:0] pa = 5'h05;
	logic mdc, st_drv, st_en, mdio_w, mdio_out, mdio_oe;
	logic pair_swap, auto_cross_en, rxer, link_led, insert_idles, neg_restart;
	logic super_isolate, link_pulse_en, serial_mode;
	int rxer_cnt = 0, idle_cnt = 0, rst_cnt = 0, cycles = 0, mismatches = 0, compares = 0;
	int c0;
	always #2.5 mclk = ~mclk;
	always #20 tx_clk = ~tx_clk;
	// pull-up on the shared data line
	assign mdio_w = mdio_oe ? mdio_out : (st_en ? st_drv : 1'b1);
	pas_station_model i_pas_station_model (.mdc(mdc), .mdio_drv(st_drv), .mdio_en(st_en),
		.mdio_w(mdio_w));
	pas_aux_regs i_pas_aux_regs (.mclk(mclk), .reset(reset), .mdc(mdc), .mdio_in(mdio_w),
		.mdio_out(mdio_out), .mdio_oe(mdio_oe), .port_addr(pa),
		.negotiation_enable_pin(negotiation_enable_pin),
		.force_fast_speed_pin(force_fast_speed_pin), .tx_clk(tx_clk), .tx_en(tx_en),
		.ctl_neg_enable(ctl_neg_enable), .ctl_speed_select(ctl_speed_select),
		.cross_detected(cross_detected), .speed_fast(speed_fast), .full_duplex(full_duplex),
		.manch_err_evt(manch_err_evt), .eof_err_evt(eof_err_evt), .link_up(link_up),
		.neg_done(neg_done), .ack_done(ack_done), .ack_seen(ack_seen),
		.ability_wait(ability_wait), .result_load(result_load), .result_in(result_in),
		.pair_swap(pair_swap), .auto_cross_en(auto_cross_en), .rxer(rxer),
		.link_led(link_led), .insert_idles(insert_idles), .neg_restart(neg_restart),
		.super_isolate(super_isolate), .link_pulse_en(link_pulse_en),
		.serial_mode(serial_mode));
	// pulse counters; a single count catches stuck or doubled pulses
	always @(posedge mclk) begin
		rxer_cnt += int'(rxer === 1'b1);
		idle_cnt += int'(insert_idles === 1'b1);
		rst_cnt += int'(neg_restart === 1'b1);
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			give_verdict();
		end
	end
	// ****************************************
	// access and compare tasks
	// ****************************************
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] dummy;
		// callers keep reserved bits at their defaults
		i_pas_station_model.frame(pas_pkg::OP_WR, tgt, a, d, dummy);
		settle(10);
	endtask
	task automatic chk_rd(input string n, input logic [4:0] a, input logic [15:0] e);
		logic [15:0] d;
		i_pas_station_model.frame(pas_pkg::OP_RD, tgt, a, 16'h0000, d);
		settle(10);
		chk(n, e, d);
	endtask
	function automatic logic [15:0] outs();
		return {7'h00, pair_swap, auto_cross_en, link_led, super_isolate, link_pulse_en,
			serial_mode, rxer, insert_idles, neg_restart};
	endfunction
	function automatic logic [15:0] exp_st(input logic fs, input logic ad, input logic [1:0] fl);
		logic b3, b2;
		b3 = ctl_neg_enable & negotiation_enable_pin;
		b2 = ~((~negotiation_enable_pin & ~force_fast_speed_pin) |
			(~ctl_neg_enable & ~ctl_speed_select));
		return {2'b00, fs | (~ad & cross_detected), fs, ad, fl, 5'h00, b3, b2, speed_fast,
			full_duplex};
	endfunction
	task automatic evt(input logic [1:0] e);
		{manch_err_evt, eof_err_evt} = e;
		settle(1);
		{manch_err_evt, eof_err_evt} = 2'b00;
		settle(3);
	endtask
	task automatic gap(input int n, input int e);
		c0 = idle_cnt;
		repeat (2) @(negedge tx_clk);
		tx_en = 1'b1;
		repeat (3) @(negedge tx_clk);
		tx_en = 1'b0;
		repeat (n) @(negedge tx_clk);
		tx_en = 1'b1;
		repeat (3) @(negedge tx_clk);
		tx_en = 1'b0;
		repeat (8) @(negedge tx_clk);
		settle(1);
		chk("idle pulses", 16'(e), 16'(idle_cnt - c0));
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		settle(6);
		reset = 1'b0;
		settle(3);
		chk("reset outputs", 16'h0090, outs());
		chk_rd("status", pas_pkg::REG_ERR_STAT, exp_st(0, 0, 0));
		chk_rd("mode", pas_pkg::REG_MODE, 16'h0000);
		chk_rd("multi", pas_pkg::REG_MPORT, 16'h0000);
		for (int i = 0; i < 16; i++) begin
			{negotiation_enable_pin, force_fast_speed_pin, ctl_neg_enable, ctl_speed_select} = 4'(i);
			speed_fast = i[0] ^ i[2];
			full_duplex = i[1];
			chk_rd("status pins", pas_pkg::REG_ERR_STAT, exp_st(0, 0, 0));
		end
		{negotiation_enable_pin, ctl_neg_enable, speed_fast, full_duplex} = 4'b1100;
		cross_detected = 1'b1;
		chk_rd("auto swap", pas_pkg::REG_ERR_STAT, exp_st(0, 0, 0));
		wr(pas_pkg::REG_ERR_STAT, 16'h0800);
		chk("cross off", 16'h0000, outs() & 16'h0180);
		chk_rd("cross off rd", pas_pkg::REG_ERR_STAT, exp_st(0, 1, 0));
		wr(pas_pkg::REG_ERR_STAT, 16'h1800);
		chk("forced swap", 16'h0100, outs() & 16'h0180);
		chk_rd("forced swap rd", pas_pkg::REG_ERR_STAT, exp_st(1, 1, 0));
		wr(pas_pkg::REG_ERR_STAT, 16'h0000);
		chk("auto cross", 16'h0180, outs() & 16'h0180);
		cross_detected = 1'b0;
		settle(4);
		chk("straight", 16'h0080, outs() & 16'h0180);
		for (int k = 0; k < 2; k++) begin
			speed_fast = k[0];
			c0 = rxer_cnt;
			evt(2'b10);
			evt(2'b01);
			chk("rxer pulses", k ? 16'h0000 : 16'h0002, 16'(rxer_cnt - c0));
			chk_rd("flags", pas_pkg::REG_ERR_STAT, exp_st(0, 0, k ? 2'b00 : 2'b11));
			chk_rd("flags cleared", pas_pkg::REG_ERR_STAT, exp_st(0, 0, 0));
		end
		speed_fast = 1'b0;
		evt(2'b10);
		reset = 1'b1;
		settle(3);
		reset = 1'b0;
		settle(3);
		chk_rd("flags after reset", pas_pkg::REG_ERR_STAT, exp_st(0, 0, 0));
		link_up = 1'b1;
		wr(pas_pkg::REG_MODE, 16'h0008);
		chk("led off", 16'h0000, outs() & 16'h0040);
		chk_rd("mode rd", pas_pkg::REG_MODE, 16'h0008);
		wr(pas_pkg::REG_MODE, 16'h0002);
		chk("led on", 16'h0040, outs() & 16'h0040);
		for (int n = 1; n <= 5; n++) begin
			gap(n, n <= 4);
		end
		wr(pas_pkg::REG_MODE, 16'h0000);
		gap(2, 0);
		for (int j = 0; j < 5; j++) begin
			result_in = 5'(1 << j);
			result_load = 1'b1;
			settle(1);
			result_load = 1'b0;
			chk_rd("result", pas_pkg::REG_MPORT, {result_in, 11'h000});
		end
		{neg_done, ack_done, ack_seen, ability_wait} = 4'b1010;
		chk_rd("progress a", pas_pkg::REG_MPORT, 16'h80a0);
		{neg_done, ack_done, ack_seen, ability_wait} = 4'b0101;
		chk_rd("progress b", pas_pkg::REG_MPORT, 16'h8050);
		c0 = rst_cnt;
		wr(pas_pkg::REG_MPORT, 16'h0100);
		chk("restart", 16'h0001, 16'(rst_cnt - c0));
		chk_rd("after restart", pas_pkg::REG_MPORT, 16'h0050);
		wr(pas_pkg::REG_MPORT, 16'h0000);
		ctl_neg_enable = 1'b0;
		wr(pas_pkg::REG_MPORT, 16'h0100);
		ctl_neg_enable = 1'b1;
		chk("restart gated", 16'h0001, 16'(rst_cnt - c0));
		wr(pas_pkg::REG_MPORT, 16'h000a);
		chk("isolate serial", 16'h0028, outs() & 16'h0038);
		chk_rd("multi rd", pas_pkg::REG_MPORT, 16'h005a);
		speed_fast = 1'b1;
		settle(4);
		chk("serial at 100", 16'h0020, outs() & 16'h0038);
		speed_fast = 1'b0;
		wr(pas_pkg::REG_MPORT, 16'h0000);
		chk("normal", 16'h0010, outs() & 16'h0038);
		tgt = 5'h06;
		chk_rd("other port", pas_pkg::REG_ERR_STAT, 16'hffff);
		wr(pas_pkg::REG_MPORT, 16'h000a);
		tgt = pa;
		chk("other port wr", 16'h0010, outs() & 16'h0038);
		chk_rd("unmapped", 5'h10, 16'h0000);
		give_verdict();
	end
endmodule
`default_nettype wire
